// file: common/csc_regs.vh
// Constants of the chip-level configuration register bank.
// Included by the core; holds definitions only.
`ifndef CSC_REGS_VH
`define CSC_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CSC_IDX_LDN 8'h07
`define CSC_IDX_ADDR_LOW 8'h26
`define CSC_IDX_ADDR_HIGH 8'h27
`define CSC_IDX_RSVD_A 8'h28
`define CSC_IDX_RSVD_VENDOR 8'h29
`define CSC_IDX_TEST_F 8'h2a
`define CSC_IDX_TEST_D 8'h2b
`define CSC_IDX_TEST_E 8'h2c
`define CSC_IDX_TEST_A 8'h2d
`define CSC_IDX_TEST_B 8'h2e
`define CSC_IDX_TEST_C 8'h2f
`define CSC_IDX_BANK_FIRST 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSC_TEST_E_KBC_RST_BIT 6

// ----------------------------------------
// Bank geometry
// ----------------------------------------
`define CSC_BANK_COUNT 4'h9
`define CSC_BANK_SIZE 11'h0d0
`define CSC_BANK_WORDS 1872

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSC_RST_ADDR_HIGH 8'h00
`define CSC_RST_ADDR_LOW_SEL0 8'h2e
`define CSC_RST_ADDR_LOW_SEL1 8'h4e
`define CSC_RST_TEST 8'h00
`define CSC_RST_LDN 8'h00
`define CSC_RST_INDEX 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSC_STRAP_SETTLE 2'h3

`endif

// file: core/csc_config_space.v
// Chip-level configuration register bank with relocatable index/data ports.
// Assumes host port strobes are one-cycle pulses on i_mclk; the strap and the
// standby and host bus resets come from pins and are synchronised here.
`timescale 1ns/100ps
`include "csc_regs.vh"

// Notes on behaviour
// - Read/write high byte of config port address
// - Indices 0x28, 0x29 ignore writes, read zero
// - Test register E bit 6 resets keyboard controller
// - New base decoded immediately, no delay
// - Low byte first; high byte write applies base
// - Base resets only on host bus/main reset
// - Strap selects default port 0x02e or 0x04e
// - Nine register banks from index 0x30 upward
// - Bank chosen by logical device number 0x07
// - Index port latches index; data port uses it
// - Access only while in configuration state
module csc_config_space (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_stby_por,
  input wire i_host_rst_b,
  input wire i_strap_sel,
  input wire i_cfg_state,
  input wire [15:0] i_io_addr,
  input wire [7:0] i_io_wdata,
  input wire i_io_wr,
  input wire i_io_rd,
  output wire o_io_hit,
  output wire [7:0] o_io_rdata,
  output wire o_io_rvalid,
  output wire [15:0] o_cfg_base,
  output wire [7:0] o_ldn,
  output wire o_kbc_rst
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg stby_meta_q;
  reg stby_sync_q;
  reg hrst_meta_q;
  reg hrst_sync_q;
  reg strap_meta_q;
  reg strap_sync_q;

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stby_meta_q <= 1'b0;
      stby_sync_q <= 1'b0;
      hrst_meta_q <= 1'b0;
      hrst_sync_q <= 1'b0;
      strap_meta_q <= 1'b0;
      strap_sync_q <= 1'b0;
    end else begin
      stby_meta_q <= i_stby_por;
      stby_sync_q <= stby_meta_q;
      // Inverted so every sync stage is active high
      hrst_meta_q <= ~i_host_rst_b;
      hrst_sync_q <= hrst_meta_q;
      strap_meta_q <= i_strap_sel;
      strap_sync_q <= strap_meta_q;
    end
  end

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  // Strap must pass the synchroniser before it is trusted
  reg [1:0] settle_q;
  reg strap_done_q;
  wire strap_load;

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (settle_q == `CSC_STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  assign strap_load = (!strap_done_q && settle_q == `CSC_STRAP_SETTLE) || hrst_sync_q;

  function [7:0] dflt_low;
    input sel;
    begin
      dflt_low = sel ? `CSC_RST_ADDR_LOW_SEL1 : `CSC_RST_ADDR_LOW_SEL0;
    end
  endfunction

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  reg [15:0] base_q;
  reg [7:0] idx_q;
  reg [7:0] ldn_q;
  reg [7:0] addr_low_q;
  reg [7:0] addr_high_q;
  reg [7:0] test_q [0:5];
  reg [7:0] rdata_q;
  reg rvalid_q;
  wire hit_idx;
  wire hit_data;
  wire wr_idx;
  wire wr_data;
  wire rd_data;
  wire in_bank;
  wire bank_ok;
  wire [10:0] bank_addr;
  wire [2:0] test_sel;
  wire is_test;

  // Ports answer only inside configuration state
  assign hit_idx = i_cfg_state && (i_io_addr == base_q);
  assign hit_data = i_cfg_state && (i_io_addr == (base_q + 16'h0001));
  assign o_io_hit = hit_idx || hit_data;
  assign wr_idx = hit_idx && i_io_wr;
  assign wr_data = hit_data && i_io_wr;
  assign rd_data = hit_data && i_io_rd;

  // ----------------------------------------
  // Bank addressing
  // ----------------------------------------
  function [10:0] bank_index;
    input [7:0] ldn;
    input [7:0] idx;
    begin
      bank_index = {7'h00, ldn[3:0]} * `CSC_BANK_SIZE + {3'h0, idx}
        - {3'h0, `CSC_IDX_BANK_FIRST};
    end
  endfunction

  assign in_bank = (idx_q >= `CSC_IDX_BANK_FIRST);
  // Numbers beyond the last bank leave every bank untouched
  assign bank_ok = in_bank && (ldn_q < {4'h0, `CSC_BANK_COUNT});
  assign bank_addr = bank_index(ldn_q, idx_q);

  function [2:0] test_slot;
    input [7:0] idx;
    begin
      test_slot = idx[2:0] - 3'h2;
    end
  endfunction

  assign is_test = (idx_q >= `CSC_IDX_TEST_F) && (idx_q <= `CSC_IDX_TEST_C);
  assign test_sel = test_slot(idx_q);

  // ----------------------------------------
  // Chip index decode
  // ----------------------------------------
  // Shared by write and read sides so both see one decode
  wire sel_ldn;
  wire sel_low;
  wire sel_high;
  wire sel_rsvd;
  wire wr_ldn;
  wire wr_low;
  wire wr_high;
  wire wr_test;
  wire wr_bank;

  assign sel_ldn = (idx_q == `CSC_IDX_LDN);
  assign sel_low = (idx_q == `CSC_IDX_ADDR_LOW);
  assign sel_high = (idx_q == `CSC_IDX_ADDR_HIGH);
  // Reserved indices get no write strobe and read as zero
  assign sel_rsvd = (idx_q == `CSC_IDX_RSVD_A) || (idx_q == `CSC_IDX_RSVD_VENDOR);
  assign wr_ldn = wr_data && sel_ldn;
  assign wr_low = wr_data && sel_low;
  assign wr_high = wr_data && sel_high;
  assign wr_test = wr_data && is_test;
  assign wr_bank = wr_data && bank_ok;

  // ----------------------------------------
  // Index, device number and address bytes
  // ----------------------------------------
  // Host bus reset clears the index and device number as well
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_q <= `CSC_RST_INDEX;
      ldn_q <= `CSC_RST_LDN;
    end else if (hrst_sync_q) begin
      idx_q <= `CSC_RST_INDEX;
      ldn_q <= `CSC_RST_LDN;
    end else begin
      if (wr_idx) begin
        idx_q <= i_io_wdata;
      end
      if (wr_ldn) begin
        ldn_q <= i_io_wdata;
      end
    end
  end

  // Standby reset leaves the port location alone
  // Host reset reload outranks a relocation write in the same cycle
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_q <= 16'h0000;
      addr_low_q <= 8'h00;
      addr_high_q <= `CSC_RST_ADDR_HIGH;
    end else if (strap_load) begin
      base_q <= {`CSC_RST_ADDR_HIGH, dflt_low(strap_sync_q)};
      addr_low_q <= dflt_low(strap_sync_q);
      addr_high_q <= `CSC_RST_ADDR_HIGH;
    end else if (wr_low) begin
      addr_low_q <= i_io_wdata;
    end else if (wr_high) begin
      addr_high_q <= i_io_wdata;
      // Low byte is only staged; the move happens here
      base_q <= {i_io_wdata, addr_low_q};
    end
  end

  // ----------------------------------------
  // Factory test registers
  // ----------------------------------------
  integer t;

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (t = 0; t < 6; t = t + 1) begin
        test_q[t] <= `CSC_RST_TEST;
      end
    end else if (stby_sync_q) begin
      for (t = 0; t < 6; t = t + 1) begin
        test_q[t] <= `CSC_RST_TEST;
      end
    end else if (wr_test) begin
      // Stored as written; the host is expected to leave these alone
      test_q[test_sel] <= i_io_wdata;
    end
  end

  // Slot follows the index decode so the output tracks register E
  assign o_kbc_rst = test_q[test_slot(`CSC_IDX_TEST_E)][`CSC_TEST_E_KBC_RST_BIT];

  // ----------------------------------------
  // Logical device banks
  // ----------------------------------------
  // Bank contents carry no reset; their layouts live in the units
  reg [7:0] bank_mem [0:`CSC_BANK_WORDS-1];

  always @(posedge i_mclk) begin
    if (wr_bank) begin
      bank_mem[bank_addr] <= i_io_wdata;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [7:0] chip_rd;

  always @* begin
    chip_rd = 8'h00;
    if (sel_ldn) begin
      chip_rd = ldn_q;
    end else if (sel_low) begin
      chip_rd = addr_low_q;
    end else if (sel_high) begin
      chip_rd = addr_high_q;
    end else if (sel_rsvd) begin
      chip_rd = 8'h00;
    end else if (is_test) begin
      chip_rd = test_q[test_sel];
    end
  end

  // Registered read keeps the bank a plain synchronous memory
  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= (hit_idx || hit_data) && i_io_rd;
      // Index port read returns the latched index
      if (hit_idx && i_io_rd) begin
        rdata_q <= idx_q;
      end else if (rd_data && in_bank) begin
        rdata_q <= bank_ok ? bank_mem[bank_addr] : 8'h00;
      end else if (rd_data) begin
        rdata_q <= chip_rd;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_io_rdata = rdata_q;
  assign o_io_rvalid = rvalid_q;
  assign o_cfg_base = base_q;
  assign o_ldn = ldn_q;

endmodule

// file: bench/csc_checker.sv
// Port checker for the configuration register bank.
// Assumes one clock, i_mclk, and async active-low main reset i_rst_b.
`timescale 1ns/100ps
module csc_checker (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_stby_por,
  input wire i_host_rst_b,
  input wire i_cfg_state,
  input wire [15:0] i_io_addr,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire o_io_hit,
  input wire [7:0] o_io_rdata,
  input wire o_io_rvalid,
  input wire [15:0] o_cfg_base,
  input wire o_kbc_rst
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_rd_hit;
    i_io_rd && o_io_hit;
  endsequence
  // Six quiet cycles cover strap load and host reset sync lag
  sequence s_base_quiet;
    (i_host_rst_b && !i_io_wr) [*6];
  endsequence
  sequence s_kbc_quiet;
    (!i_io_wr && !i_stby_por) [*5];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_answer: assert property (s_rd_hit |=> o_io_rvalid)
    else $error("read hit without answer");
  a_stray_valid: assert property (!(i_io_rd && o_io_hit) |=> !o_io_rvalid)
    else $error("answer without read hit");
  a_hit_cfg: assert property (o_io_hit |-> i_cfg_state)
    else $error("hit outside config state");
  a_hit_addr: assert property (o_io_hit |-> (i_io_addr == o_cfg_base ||
    i_io_addr == o_cfg_base + 16'h0001)) else $error("hit off base");
  a_index_port: assert property (i_cfg_state && i_io_addr == o_cfg_base |-> o_io_hit)
    else $error("index port missed");
  a_base_quiet: assert property (s_base_quiet |-> $stable(o_cfg_base))
    else $error("base moved without cause");
  a_kbc_quiet: assert property (s_kbc_quiet |-> $stable(o_kbc_rst))
    else $error("kbc reset moved without cause");
  a_kbc_stby: assert property (i_stby_por [*6] |-> !o_kbc_rst)
    else $error("kbc reset kept in standby reset");
  a_rdata_hold: assert property ($changed(o_io_rdata) |-> o_io_rvalid)
    else $error("read data moved without answer");
endmodule

bind csc_config_space csc_checker u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_stby_por(i_stby_por), .i_host_rst_b(i_host_rst_b), .i_cfg_state(i_cfg_state),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_hit(o_io_hit),
  .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid), .o_cfg_base(o_cfg_base),
  .o_kbc_rst(o_kbc_rst));

// file: bench/csc_host_model.sv
// Host bus controller model issuing index/data port cycles.
// Assumes one-cycle strobes launched at the falling edge of i_mclk.
`timescale 1ns/100ps
module csc_host_model (
  input wire i_mclk,
  input wire [7:0] i_rdata,
  input wire i_rvalid,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  logic [15:0] base = 16'h002e;
  logic [7:0] dq;
  logic dok;
  initial begin
    o_addr = 16'hffff;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = !w;
    @(negedge i_mclk);
    q = i_rdata;
    ok = i_rvalid;
    // Released lines flip so stale values never pass
    o_addr = ~a;
    o_wdata = ~d;
    o_wr = 1'b0;
    o_rd = 1'b0;
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
    cyc(1'b1, base, idx, dq, dok);
    cyc(1'b1, base + 16'h0001, v, dq, dok);
  endtask
  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] q, output logic ok);
    cyc(1'b1, base, idx, q, ok);
    cyc(1'b0, base + 16'h0001, 8'h00, q, ok);
  endtask
endmodule

// file: bench/csc_config_space_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model on the ports and the bound checker.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module csc_config_space_tb;
  logic mclk = 0, rst_b = 0, stby = 0, hrst_b = 1, strap = 0, cfg = 1, ok;
  logic [7:0] q;
  wire [15:0] addr, base;
  wire [7:0] wdata, rdata, ldn;
  wire wr, rd, hit, rvalid, kbc;
  int errors = 0, num_checks = 0;
  csc_config_space dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_stby_por(stby),
    .i_host_rst_b(hrst_b), .i_strap_sel(strap), .i_cfg_state(cfg), .i_io_addr(addr),
    .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd), .o_io_hit(hit), .o_io_rdata(rdata),
    .o_io_rvalid(rvalid), .o_cfg_base(base), .o_ldn(ldn), .o_kbc_rst(kbc));
  csc_host_model host (.i_mclk(mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  initial forever #2 mclk = ~mclk;
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task t_reset;
    `CHK(base, 16'h002e)
    host.cfg_rd(8'h2c, q, ok);
    `CHK({ok, q, kbc}, 10'h200)
    $display("reset done");
  endtask
  task t_reloc;
    // Even base, low byte first
    host.cfg_wr(8'h26, 8'h70);
    `CHK(base, 16'h002e)
    host.cfg_wr(8'h27, 8'h03);
    `CHK(base, 16'h0370)
    host.base = 16'h0370;
    host.cfg_rd(8'h27, q, ok);
    `CHK({ok, q}, 9'h103)
    host.cfg_rd(8'h26, q, ok);
    `CHK({ok, q}, 9'h170)
    $display("reloc done");
  endtask
  task t_rsvd;
    for (int i = 8'h28; i < 8'h2a; i++) begin
      host.cfg_wr(i[7:0], 8'hff);
      host.cfg_rd(i[7:0], q, ok);
      `CHK({ok, q}, 9'h100)
    end
    host.cyc(1'b0, host.base, 8'h00, q, ok);
    `CHK({ok, q}, 9'h129)
    $display("rsvd done");
  endtask
  task t_bank;
    host.cfg_wr(8'h07, 8'h00);
    host.cfg_wr(8'h30, 8'h11);
    host.cfg_wr(8'h07, 8'h08);
    host.cfg_wr(8'h30, 8'h88);
    host.cfg_rd(8'h30, q, ok);
    `CHK({ok, q, ldn}, 17'h18808)
    host.cfg_wr(8'h07, 8'h09);
    host.cfg_wr(8'h30, 8'h99);
    host.cfg_rd(8'h30, q, ok);
    `CHK({ok, q}, 9'h100)
    host.cfg_wr(8'h07, 8'h00);
    host.cfg_rd(8'h30, q, ok);
    `CHK({ok, q}, 9'h111)
    $display("bank done");
  endtask
  task t_kbc;
    host.cfg_wr(8'h2c, 8'h40);
    @(negedge mclk);
    `CHK(kbc, 1'b1)
    stby = 1;
    repeat (8) @(negedge mclk);
    stby = 0;
    repeat (4) @(negedge mclk);
    `CHK({kbc, base}, 17'h00370)
    $display("kbc done");
  endtask
  task t_host;
    host.cfg_wr(8'h2c, 8'h40);
    strap = 1;
    hrst_b = 0;
    repeat (6) @(negedge mclk);
    hrst_b = 1;
    repeat (4) @(negedge mclk);
    host.base = 16'h004e;
    `CHK({kbc, base}, 17'h1004e)
    cfg = 0;
    host.cfg_wr(8'h2c, 8'h00);
    host.cfg_rd(8'h2c, q, ok);
    `CHK({ok, kbc}, 2'b01)
    cfg = 1;
    $display("host done");
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst_b = 1;
    repeat (6) @(negedge mclk);
    t_reset();
    t_reloc();
    t_rsvd();
    t_bank();
    t_kbc();
    t_host();
    close_out();
  end
  initial begin
    #20000;
    errors++;
    close_out();
  end
endmodule
